// >>> sat_pkg.sv
// package: register map, field layout and constants of the split auto-reload timer
`default_nettype none
package sat_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_CLKCTL = 8'h0C;
  localparam logic [7:0] ADDR_IRQEN = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int COUNT_W = 16;
  localparam int CTRL_W = 8;
  localparam int FLAG_W = 2;
  localparam int FLAG_LOW = 0;
  localparam int FLAG_HIGH = 1;
  localparam int CLK_LOW_BIT = 0;
  localparam int CLK_HIGH_BIT = 1;
  localparam int IRQEN_BIT = 0;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h3;
  localparam logic [1:0] CLK_RST = 2'h0;
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;

  // ----------------------------------------------------------------
  // timer control register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_irq_enable;
    logic capture_unused;
    logic split_mode_sel;
    logic run_control;
    logic unused1;
    logic ext_clock_sel;
  } sat_ctrl_t;

  localparam sat_ctrl_t CTRL_RST = '0;

endpackage : sat_pkg

`default_nettype wire

// >>> sat_timer.sv
// module: split auto-reload timer with apb register access
// Operation
// RULE_01: two 8-bit count bytes form one 16-bit count value
// RULE_02: split bit 3 of control picks one 16-bit or two 8-bit timers
// RULE_03: count clock is system clock, system clock over 12, or external over 8
// RULE_04: external clock over 8 is synchronised into system clock before use
// RULE_05: 16-bit wrap from ffff loads reload pair and sets high flag
// RULE_06: 16-bit mode interrupts on every overflow when timer irq enabled; code also gates it with mask
// RULE_07: 16-bit mode also interrupts on low byte wrap when low irq enabled; code also gates it with timer irq enable and mask
// RULE_08: split mode reloads each byte from its own reload byte
// RULE_09: split mode run bit gates high byte only; low byte always counts
// RULE_10: per-byte clock select: 1 system clock, else ext select picks source
// RULE_11: split mode sets high and low flags on their own byte wraps
// RULE_12: split mode: high wrap always interrupts, low too with low enable; code gates both with timer irq enable and mask
// RULE_13: flags are cleared only by software, never by hardware
// RULE_14: handler reads both flags to find the interrupt source
// RULE_15: low flag sets on every low byte wrap in both modes
// RULE_16: 16-bit mode run bit gates whole count; stopped bytes hold
`timescale 1ns/1ps
`default_nettype none

module sat_timer #(
  parameter int SYS_DIV = sat_pkg::SYS_DIV,
  parameter int EXT_DIV = sat_pkg::EXT_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_osc,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word address match, shared by read mux and write strobes
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sat_pkg::sat_ctrl_t ctrl;
  logic [15:0] count;
  logic [15:0] reload;
  logic [1:0] clk_sel;
  logic irq_en;
  logic [1:0] mask;
  logic [3:0] sys_cnt;
  logic [2:0] ext_cnt;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_last;
  logic sys_tick;
  logic ext_tick;
  logic low_tick;
  logic high_tick;
  logic wr_en;
  logic rd_setup;
  logic low_wrap;
  logic high_wrap;
  logic full_wrap;
  logic low_step;
  logic high_step;
  logic [1:0] set_flag;
  logic [1:0] flags;
  logic next_irq;
  logic [31:0] next_prdata;
  logic mapped;
  sat_pkg::sat_ctrl_t wr_ctrl;

  // apb access phase write; setup phase used to fetch read data
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign wr_ctrl = sat_pkg::sat_ctrl_t'(pwdata[7:0]); // write data seen in control layout

  // ----------------------------------------------------------------
  // count clock sources
  // ----------------------------------------------------------------
  // the external oscillator is asynchronous; two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
    end else begin
      ext_sync1 <= ext_osc;
      ext_sync2 <= ext_sync1; // [RULE_04]
    end
  end

  // divide synchronised rising edges of the oscillator by eight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_last <= 1'b0;
      ext_cnt <= '0;
      ext_tick <= 1'b0;
    end else begin
      ext_last <= ext_sync2;
      ext_tick <= 1'b0;
      if (ext_sync2 && !ext_last) begin
        if (ext_cnt == 3'(EXT_DIV - 1)) begin
          ext_cnt <= '0;
          ext_tick <= 1'b1; // [RULE_03] [RULE_04]
        end else begin
          ext_cnt <= ext_cnt + 3'd1;
        end
      end
    end
  end

  // system clock over twelve, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_cnt <= '0;
    end else if (sys_cnt == 4'(SYS_DIV - 1)) begin
      sys_cnt <= '0;
    end else begin
      sys_cnt <= sys_cnt + 4'd1;
    end
  end

  assign sys_tick = (sys_cnt == 4'(SYS_DIV - 1)); // [RULE_03]

  // per-byte source choice; 16-bit mode follows the low byte select
  always_comb begin
    low_tick = ctrl.ext_clock_sel ? ext_tick : sys_tick;
    if (clk_sel[sat_pkg::CLK_LOW_BIT]) begin
      low_tick = 1'b1; // [RULE_10]
    end
    high_tick = ctrl.ext_clock_sel ? ext_tick : sys_tick;
    if (clk_sel[sat_pkg::CLK_HIGH_BIT]) begin
      high_tick = 1'b1; // [RULE_10]
    end
  end

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // low byte runs always in split mode, under run control otherwise
  always_comb begin
    if (ctrl.split_mode_sel) begin
      low_step = low_tick; // [RULE_09]
      high_step = high_tick && ctrl.run_control; // [RULE_09]
    end else begin
      low_step = low_tick && ctrl.run_control; // [RULE_16]
      high_step = low_step && (count[7:0] == sat_pkg::BYTE_MAX);
    end
  end

  assign low_wrap = low_step && (count[7:0] == sat_pkg::BYTE_MAX);
  assign full_wrap = !ctrl.split_mode_sel && low_step && (count == sat_pkg::COUNT_MAX);
  assign high_wrap = ctrl.split_mode_sel ? (high_step && (count[15:8] == sat_pkg::BYTE_MAX)) : full_wrap;

  // low byte: reloads on its own wrap in split mode or on a 16-bit wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count[7:0] <= sat_pkg::COUNT_RST[7:0];
    end else if (wr_en && hit(paddr, sat_pkg::ADDR_COUNT)) begin
      count[7:0] <= pwdata[7:0]; // software write wins over counting
    end else if (full_wrap || (ctrl.split_mode_sel && low_wrap)) begin
      count[7:0] <= reload[7:0]; // [RULE_05] [RULE_08]
    end else if (low_step) begin
      count[7:0] <= count[7:0] + 8'd1; // [RULE_01]
    end
  end

  // high byte: carry from low byte in 16-bit mode, own clock in split
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count[15:8] <= sat_pkg::COUNT_RST[15:8];
    end else if (wr_en && hit(paddr, sat_pkg::ADDR_COUNT)) begin
      count[15:8] <= pwdata[15:8];
    end else if (high_wrap) begin
      count[15:8] <= reload[15:8]; // [RULE_05] [RULE_08]
    end else if (high_step) begin
      count[15:8] <= count[15:8] + 8'd1; // [RULE_01] [RULE_16]
    end
  end

  // ----------------------------------------------------------------
  // overflow flags
  // ----------------------------------------------------------------
  always_comb begin
    set_flag = '0;
    set_flag[sat_pkg::FLAG_HIGH] = high_wrap; // [RULE_05] [RULE_11]
    set_flag[sat_pkg::FLAG_LOW] = low_wrap; // [RULE_11] [RULE_15]
  end

  assign flags = {ctrl.high_overflow_flag, ctrl.low_overflow_flag};

  // flags clear by writing zero in control or one in status; a
  // wrap in the same cycle still sets, so no overflow is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.high_overflow_flag <= 1'b0;
      ctrl.low_overflow_flag <= 1'b0;
    end else begin
      if (wr_en && hit(paddr, sat_pkg::ADDR_CTRL)) begin
        ctrl.high_overflow_flag <= wr_ctrl.high_overflow_flag | set_flag[sat_pkg::FLAG_HIGH]; // [RULE_13]
        ctrl.low_overflow_flag <= wr_ctrl.low_overflow_flag | set_flag[sat_pkg::FLAG_LOW]; // [RULE_13]
      end else if (wr_en && hit(paddr, sat_pkg::ADDR_STATUS)) begin
        ctrl.high_overflow_flag <= (flags[sat_pkg::FLAG_HIGH] & ~pwdata[sat_pkg::FLAG_HIGH])
                                   | set_flag[sat_pkg::FLAG_HIGH]; // [RULE_13]
        ctrl.low_overflow_flag <= (flags[sat_pkg::FLAG_LOW] & ~pwdata[sat_pkg::FLAG_LOW])
                                  | set_flag[sat_pkg::FLAG_LOW]; // [RULE_13]
      end else begin
        ctrl.high_overflow_flag <= flags[sat_pkg::FLAG_HIGH] | set_flag[sat_pkg::FLAG_HIGH];
        ctrl.low_overflow_flag <= flags[sat_pkg::FLAG_LOW] | set_flag[sat_pkg::FLAG_LOW];
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // control bits other than the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.low_irq_enable <= sat_pkg::CTRL_RST.low_irq_enable;
      ctrl.capture_unused <= sat_pkg::CTRL_RST.capture_unused;
      ctrl.split_mode_sel <= sat_pkg::CTRL_RST.split_mode_sel;
      ctrl.run_control <= sat_pkg::CTRL_RST.run_control;
      ctrl.unused1 <= sat_pkg::CTRL_RST.unused1;
      ctrl.ext_clock_sel <= sat_pkg::CTRL_RST.ext_clock_sel;
    end else if (wr_en && hit(paddr, sat_pkg::ADDR_CTRL)) begin
      ctrl.low_irq_enable <= wr_ctrl.low_irq_enable;
      ctrl.capture_unused <= 1'b0; // capture mode not built, reads zero
      ctrl.split_mode_sel <= wr_ctrl.split_mode_sel; // [RULE_02]
      ctrl.run_control <= wr_ctrl.run_control;
      ctrl.unused1 <= 1'b0;
      ctrl.ext_clock_sel <= wr_ctrl.ext_clock_sel;
    end
  end

  // reload pair, clock selects, timer irq enable and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload <= sat_pkg::COUNT_RST;
      clk_sel <= sat_pkg::CLK_RST;
      irq_en <= 1'b0;
      mask <= sat_pkg::MASK_RST;
    end else if (wr_en) begin
      if (hit(paddr, sat_pkg::ADDR_RELOAD)) begin
        reload <= pwdata[15:0];
      end
      if (hit(paddr, sat_pkg::ADDR_CLKCTL)) begin
        clk_sel <= pwdata[1:0];
      end
      if (hit(paddr, sat_pkg::ADDR_IRQEN)) begin
        irq_en <= pwdata[sat_pkg::IRQEN_BIT];
      end
      if (hit(paddr, sat_pkg::ADDR_MASK)) begin
        mask <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // level output; low flag joins only with low irq enable in both modes
  always_comb begin
    next_irq = irq_en && flags[sat_pkg::FLAG_HIGH] && mask[sat_pkg::FLAG_HIGH]; // [RULE_06] [RULE_12]
    if (irq_en && ctrl.low_irq_enable && flags[sat_pkg::FLAG_LOW] && mask[sat_pkg::FLAG_LOW]) begin
      next_irq = 1'b1; // [RULE_07] [RULE_12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------
  // read data is captured in setup so it comes from a flop in access;
  // a count read therefore shows the value one cycle before the answer
  always_comb begin
    next_prdata = sat_pkg::ZERO_WORD;
    mapped = 1'b1;
    if (hit(paddr, sat_pkg::ADDR_CTRL)) begin
      next_prdata[7:0] = ctrl;
    end else if (hit(paddr, sat_pkg::ADDR_COUNT)) begin
      next_prdata[15:0] = count;
    end else if (hit(paddr, sat_pkg::ADDR_RELOAD)) begin
      next_prdata[15:0] = reload;
    end else if (hit(paddr, sat_pkg::ADDR_CLKCTL)) begin
      next_prdata[1:0] = clk_sel;
    end else if (hit(paddr, sat_pkg::ADDR_IRQEN)) begin
      next_prdata[sat_pkg::IRQEN_BIT] = irq_en;
    end else if (hit(paddr, sat_pkg::ADDR_STATUS)) begin
      next_prdata[1:0] = flags; // [RULE_14]
    end else if (hit(paddr, sat_pkg::ADDR_MASK)) begin
      next_prdata[1:0] = mask;
    end else begin
      mapped = 1'b0;
    end
  end

  // pready is high from the first edge after reset: no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= sat_pkg::ZERO_WORD;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        prdata <= pwrite ? sat_pkg::ZERO_WORD : next_prdata;
        pslverr <= !mapped; // unmapped address answers with an error
      end
    end
  end

endmodule : sat_timer

`default_nettype wire

// >>> sat_timer_properties.sv
// checker: port-level properties of the split auto-reload timer
`timescale 1ns/1ps
`default_nettype none
module sat_timer_properties #(
  parameter int SYS_DIV = sat_pkg::SYS_DIV,
  parameter int EXT_DIV = sat_pkg::EXT_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_osc,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic acc;
  logic unmapped;
  logic en_seen;
  logic [1:0] flags_seen;
  // a transfer completes at the access edge; zero wait states expected
  assign acc = psel && penable && pready;
  assign unmapped = (paddr > 32'h0000_0018) || (paddr[1:0] != 2'h0);

  // irq enable as software last wrote it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen <= 1'b0;
    end else if (acc && pwrite && paddr == {24'h0, sat_pkg::ADDR_IRQEN}) begin
      en_seen <= pwdata[0];
    end
  end

  // flags shown by the last status read; any write that may clear them forgets them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_seen <= 2'h0;
    end else if (acc && pwrite && (paddr == {24'h0, sat_pkg::ADDR_STATUS} || paddr == 32'h0)) begin
      flags_seen <= 2'h0;
    end else if (acc && paddr == {24'h0, sat_pkg::ADDR_STATUS}) begin
      flags_seen <= prdata[1:0];
    end
  end

  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence setup_s;
    psel && !penable;
  endsequence

  sequence rd_setup_s(a);
    psel && !penable && !pwrite && paddr == {24'h0, a};
  endsequence

  ready_after_reset_a: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  slverr_decode_a: assert property (setup_s |=> pslverr == $past(unmapped))
    else $error("pslverr disagrees with address decode");
  empty_rdata_a: assert property (setup_s ##0 (pwrite || unmapped) |=> prdata == 32'h0000_0000)
    else $error("read data not zero for write or unmapped");
  ctrl_reserved_zero_a: assert property (
    rd_setup_s(sat_pkg::ADDR_CTRL) |=> prdata[31:8] == 24'h0 && !prdata[4] && !prdata[1])
    else $error("control reserved bits not zero");
  count_upper_zero_a: assert property (
    psel && !penable && !pwrite && (paddr == 32'h0000_0004 || paddr == 32'h0000_0008) |=> prdata[31:16] == 16'h0)
    else $error("count or reload upper half not zero");
  irqen_off_quiet_a: assert property (
    acc && pwrite && paddr == {24'h0, sat_pkg::ADDR_IRQEN} && !pwdata[0] |-> ##2 !irq)
    else $error("irq high after timer irq disabled");
  mask_off_quiet_a: assert property (
    acc && pwrite && paddr == {24'h0, sat_pkg::ADDR_MASK} && pwdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("irq high with both flags masked");
  irq_needs_enable_a: assert property (irq |-> $past(en_seen))
    else $error("irq high while timer irq disabled");
  flags_sticky_a: assert property (
    rd_setup_s(sat_pkg::ADDR_STATUS) |=> (prdata[1:0] & flags_seen) == flags_seen)
    else $error("overflow flag dropped without software clear");
endmodule : sat_timer_properties

bind sat_timer sat_timer_properties #(.SYS_DIV(SYS_DIV), .EXT_DIV(EXT_DIV)) sat_timer_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_osc(ext_osc), .irq(irq));
`default_nettype wire

// >>> tb.sv
// testbench: split auto-reload timer driven over apb
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ext_osc = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [1:0] osc_cnt = 2'h0;
  logic [31:0] seed = 32'h0000_005D;
  logic [63:0] notes[$];
  logic [15:0] val;
  int err_total = 0;
  int num_checks = 0;

  sat_timer sat_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_osc(ext_osc),
    .irq(irq));

  // ----------------------------------------
  // clock and external oscillator
  // ----------------------------------------
  always #20 pclk = ~pclk;

  // external source at one sixth of pclk, so an ext/8 tick is 48 cycles
  always @(posedge pclk) begin
    osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
    if (osc_cnt == 2'h2) begin
      ext_osc <= ~ext_osc;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; reads note their expectation for the monitor
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [31:0] mask);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, addr};
    pwdata <= wr ? data : xorshift();
    if (!wr) begin
      notes.push_back({mask, data});
    end
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask = 32'hFFFF_FFFF);
    apb(1'b0, addr, exp, mask);
  endtask : rd

  // irq is registered one edge behind its cause, three edges is ample
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // read monitor: oldest note against the data taken at the access edge;
  // every access also has its error answer checked against the map
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      check({31'h0, pslverr}, {31'h0, paddr[7:0] > sat_pkg::ADDR_MASK});
    end
    if (psel && penable && pready && !pwrite) begin
      check(prdata & notes[0][63:32], notes[0][31:0] & notes[0][63:32]);
      void'(notes.pop_front());
    end
  end

  // watchdog, several times the expected run length
  initial begin
    #(40 * 8000);
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(8'h1C, xorshift());
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), (i == 6) ? 32'h0000_0003 : 32'h0000_0000);
    end
    wr(sat_pkg::ADDR_CLKCTL, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      val = 16'(xorshift());
      wr(sat_pkg::ADDR_COUNT, {16'h0, val});
      repeat (20) @(posedge pclk);
      rd(sat_pkg::ADDR_COUNT, {16'h0, val});
    end
    wr(sat_pkg::ADDR_RELOAD, 32'h0000_FFF0);
    wr(sat_pkg::ADDR_COUNT, 32'h0000_FFF0);
    wr(sat_pkg::ADDR_IRQEN, 32'h0000_0001);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (100) @(posedge pclk);
    rd(sat_pkg::ADDR_STATUS, 32'h0000_0003);
    rd(sat_pkg::ADDR_COUNT, 32'h0000_FFF0, 32'hFFFF_FFF0);
    irq_is(1'b1);
    wr(sat_pkg::ADDR_MASK, 32'h0000_0000);
    irq_is(1'b0);
    rd(sat_pkg::ADDR_STATUS, 32'h0000_0003);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_00C0);
    repeat (50) @(posedge pclk);
    rd(sat_pkg::ADDR_STATUS, 32'h0000_0003);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(sat_pkg::ADDR_STATUS, 32'h0000_0003);
    rd(sat_pkg::ADDR_STATUS, 32'h0000_0000);
    wr(sat_pkg::ADDR_MASK, 32'h0000_0003);
    wr(sat_pkg::ADDR_COUNT, 32'h0000_10F0);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (40) @(posedge pclk);
    // flags read while running: a control write of one would set them itself
    rd(sat_pkg::ADDR_STATUS, 32'h0000_0001);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0040);
    rd(sat_pkg::ADDR_COUNT, 32'h0000_1100, 32'hFFFF_FF00);
    irq_is(1'b0);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0060);
    irq_is(1'b1);
    // split mode: high byte parked while the low byte runs
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(sat_pkg::ADDR_STATUS, 32'h0000_0003);
    wr(sat_pkg::ADDR_RELOAD, 32'h0000_80F0);
    wr(sat_pkg::ADDR_COUNT, 32'h0000_80F0);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0008);
    repeat (60) @(posedge pclk);
    rd(sat_pkg::ADDR_COUNT, 32'h0000_80F0, 32'hFFFF_FFF0);
    rd(sat_pkg::ADDR_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_004C);
    repeat (300) @(posedge pclk);
    rd(sat_pkg::ADDR_STATUS, 32'h0000_0003);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_00C8);
    rd(sat_pkg::ADDR_COUNT, 32'h0000_80F0, 32'hFFFF_80F0);
    irq_is(1'b1);
    wr(sat_pkg::ADDR_STATUS, 32'h0000_0002);
    irq_is(1'b0);
    wr(sat_pkg::ADDR_CTRL, 32'h0000_0068);
    irq_is(1'b1);
    wr(sat_pkg::ADDR_IRQEN, 32'h0000_0000);
    irq_is(1'b0);
    // slow sources: sys/12 then ext/8, two ticks to the 16-bit wrap
    for (int k = 0; k < 2; k++) begin
      wr(sat_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(sat_pkg::ADDR_STATUS, 32'h0000_0003);
      wr(sat_pkg::ADDR_CLKCTL, 32'h0000_0000);
      wr(sat_pkg::ADDR_COUNT, 32'h0000_FFFE);
      wr(sat_pkg::ADDR_CTRL, (k == 1) ? 32'h0000_0005 : 32'h0000_0004);
      repeat (10) @(posedge pclk);
      rd(sat_pkg::ADDR_STATUS, 32'h0000_0000);
      repeat (150) @(posedge pclk);
      rd(sat_pkg::ADDR_STATUS, 32'h0000_0003);
    end
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
